// *** dv/qsx_flash_model.sv ***
// behavioural quad serial flash: fast read, mode byte, in-place entry
// assumes mode-0 clocking and that the bench resolves the shared io lines
`timescale 1ns/100ps

module qsx_flash_model #(
  parameter logic [7:0] IN_PLACE_ON = 8'hA5  // arbitrary activation byte
) (
  input  wire logic       select_n_in,  // chip select
  input  wire logic       sclk_in,      // serial clock
  input  wire logic [3:0] io_in,        // resolved io lines
  output logic      [3:0] io_out,       // read data nibble
  output logic            io_oe_out,    // drives io while high
  output int              cycles_out,   // bus cycles seen
  output logic      [7:0] mode_out      // last mode byte
);
  logic [7:0]  cmd, dbyte;
  logic [23:0] addr;
  logic        in_place;
  int          n, base, j;

  function automatic logic [7:0] rom_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : rom_byte

  initial begin
    io_out = 4'h0;
    io_oe_out = 1'h0;
    cycles_out = 0;
    mode_out = 8'h00;
    in_place = 1'h0;
    n = 0;
    base = 8;
  end

  always @(negedge select_n_in) begin
    n = 0;
    base = in_place ? 0 : 8;
    cycles_out++;
  end

  // in place only while the last mode byte asked for it
  always @(posedge select_n_in) begin
    io_oe_out = 1'h0;
    in_place = (mode_out == IN_PLACE_ON);
  end

  always @(posedge sclk_in) begin
    if (!select_n_in) begin
      if (n < base)
        cmd = {cmd[6:0], io_in[0]};
      else if (n < base + 6)
        addr = {addr[19:0], io_in};
      else if (n < base + 8)
        mode_out = {mode_out[3:0], io_in};
      n++;
    end
  end

  // a wrong opcode leaves the lines undriven, so the reader gets garbage
  always @(negedge sclk_in) begin
    if (!select_n_in && n >= base + 12 && (in_place || cmd == 8'hEB)) begin
      j = n - base - 12;
      dbyte = rom_byte(addr + 24'(j / 2));
      io_out = j[0] ? dbyte[3:0] : dbyte[7:4];
      io_oe_out = 1'h1;
    end
  end
endmodule : qsx_flash_model

// *** dv/qsx_reader_asserts.sv ***
// port assertions for the quad serial flash reader, two clock domains
// assumes it is bound onto qsx_reader and sees only its ports
`timescale 1ns/100ps

module qsx_reader_chk (
  input wire logic       clk_in,         // cpu clock
  input wire logic       rst_in,         // async reset
  input wire logic       link_clk_in,    // link clock
  input wire logic       memory_mapped_access_select_in, // mapped mode
  input wire logic       cpu_req_in,     // read request
  input wire logic       cpu_ready_out,  // data pulse
  input wire logic [7:0] cpu_rdata_out,  // read data
  input wire logic       execute_in_place_status_out, // in-place on
  input wire logic       flash_select_n_out, // chip select
  input wire logic       flash_clk_out,  // serial clock
  input wire logic [3:0] flash_io_out,   // io drive
  input wire logic [3:0] flash_io_oe_out // io enable
);
  a_ready_req: assert property (
    @(posedge clk_in) disable iff (rst_in)
    cpu_ready_out |-> $past(cpu_req_in))
    else $error("ready without request");
  a_ready_pulse: assert property (
    @(posedge clk_in) disable iff (rst_in)
    cpu_ready_out |=> !cpu_ready_out)
    else $error("ready longer than one cycle");
  a_rdata_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !cpu_ready_out |-> $stable(cpu_rdata_out))
    else $error("read data moved without ready");
  a_blocked_read: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !memory_mapped_access_select_in && !$past(memory_mapped_access_select_in)
    |-> !cpu_ready_out)
    else $error("read answered while not mapped");
  // status may only move once the carrying cycle has released the flash
  a_status_quiet: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(execute_in_place_status_out) |-> $past(flash_select_n_out))
    else $error("status moved during an open cycle");
  a_idle_quiet: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    flash_select_n_out |-> flash_io_oe_out == 4'h0 && !flash_clk_out)
    else $error("io driven or clock high while deselected");
  a_io_on_fall: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    !flash_select_n_out && flash_io_oe_out != 4'h0 && $changed(flash_io_out)
    |-> $fell(flash_clk_out) || $fell(flash_select_n_out))
    else $error("io changed away from a clock fall");
  a_clk_shape: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    $rose(flash_clk_out) |=> flash_clk_out ##1 !flash_clk_out)
    else $error("serial clock high phase not two link clocks");
  c_ready: cover property (@(posedge clk_in) cpu_ready_out);
  c_enter: cover property (
    @(posedge clk_in) $rose(execute_in_place_status_out));
  c_leave: cover property (
    @(posedge clk_in) $fell(execute_in_place_status_out));
endmodule : qsx_reader_chk

bind qsx_reader qsx_reader_chk u_chk (
  .clk_in, .rst_in, .link_clk_in, .memory_mapped_access_select_in,
  .cpu_req_in, .cpu_ready_out, .cpu_rdata_out,
  .execute_in_place_status_out, .flash_select_n_out, .flash_clk_out,
  .flash_io_out, .flash_io_oe_out
);

// *** dv/test_qsx_reader.sv ***
// bench for the quad serial flash reader: cpu reads against a flash model
// assumes the model answers with a pattern the bench can recompute
`timescale 1ns/100ps

`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
  end \
end

module test_qsx_reader;
  localparam logic [7:0] ON  = 8'hA5;  // arbitrary activation byte
  localparam logic [7:0] OFF = 8'hFF;  // arbitrary termination byte

  logic        clk_in, rst_in, link_clk, sel, pf_en, xip_req, req;
  logic        ready, status, sel_n, sclk, m_oe;
  logic [7:0]  mode, rdata, m_mode;
  logic [23:0] addr;
  logic [3:0]  io_o, io_oe, io_in, m_io;
  int          cycles, fails, checked, ticks, lat, c0;

  qsx_reader uut (
    .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .memory_mapped_access_select_in(sel), .prefetch_enable_in(pf_en),
    .execute_in_place_request_in(xip_req), .mode_data_in(mode),
    .cpu_req_in(req), .cpu_addr_in(addr), .cpu_ready_out(ready),
    .cpu_rdata_out(rdata), .execute_in_place_status_out(status),
    .flash_select_n_out(sel_n), .flash_clk_out(sclk),
    .flash_io_out(io_o), .flash_io_oe_out(io_oe), .flash_io_in(io_in)
  );

  qsx_flash_model #(.IN_PLACE_ON(ON)) u_flash (
    .select_n_in(sel_n), .sclk_in(sclk), .io_in(io_in), .io_out(m_io),
    .io_oe_out(m_oe), .cycles_out(cycles), .mode_out(m_mode)
  );

  // lines driven by neither side show the inverse of the model's last nibble
  assign io_in = (io_oe & io_o) | (~io_oe & (m_oe ? m_io : ~m_io));

  always #12.5 clk_in = ~clk_in;

  initial begin
    link_clk = 1'h0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : exp_byte

  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic wait_ready(input logic [7:0] exp);
    for (lat = 0; lat < 600 && ready !== 1'h1; lat++) @(negedge clk_in);
    `CHK(ready, 1'h1)
    `CHK(rdata, exp)
    req = 1'h0;
  endtask : wait_ready

  task automatic cpu_read(input logic [23:0] a);
    @(negedge clk_in);
    req = 1'h1;
    addr = a;
    wait_ready(exp_byte(a));
  endtask : cpu_read

  task automatic wait_status(input logic v);
    for (lat = 0; lat < 200 && status !== v; lat++) @(negedge clk_in);
    `CHK(status, v)
  endtask : wait_status

  always @(posedge clk_in) begin
    ticks++;
    if (ticks == 40000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    clk_in = 1'h0;
    rst_in = 1'h1;
    sel = 1'h0;
    pf_en = 1'h0;
    xip_req = 1'h1;
    mode = ON;
    req = 1'h0;
    addr = 24'h0;
    {fails, checked, ticks} = '0;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'h0;
    `CHK(sel_n, 1'h1)
    req = 1'h1;
    addr = 24'h10;
    repeat (300) @(negedge clk_in);
    `CHK(cycles, 0)
    `CHK(status, 1'h0)
    xip_req = 1'h0;
    mode = OFF;
    sel = 1'h1;
    wait_ready(exp_byte(24'h10));
    `CHK(status, 1'h0)
    cpu_read(24'h101);
    cpu_read(24'h102);
    `CHK(cycles, 3)
    `CHK(m_mode, OFF)
    pf_en = 1'h1;
    cpu_read(24'h200);
    c0 = cycles;
    // let the buffer fill so the link has to stall
    repeat (200) @(negedge clk_in);
    for (int i = 1; i < 7; i++) begin
      cpu_read(24'h200 + 24'(i));
      // a buffered byte answers one cycle after the request is taken
      if (i < 3) `CHK(lat, 1)
    end
    `CHK(cycles, c0)
    cpu_read(24'h400);
    pf_en = 1'h0;
    cpu_read(24'h800);
    cpu_read(24'h801);
    `CHK(cycles, c0 + 3)
    mode = ON;
    xip_req = 1'h1;
    repeat (20) @(negedge clk_in);
    `CHK(status, 1'h0)
    cpu_read(24'h300);
    `CHK(m_mode, ON)
    wait_status(1'h1);
    cpu_read(24'h301);
    mode = OFF;
    xip_req = 1'h0;
    repeat (20) @(negedge clk_in);
    `CHK(status, 1'h1)
    cpu_read(24'h302);
    `CHK(m_mode, OFF)
    wait_status(1'h0);
    cpu_read(24'h303);
    finish_test();
  end
endmodule : test_qsx_reader

// *** hdl/qsx_pkg.sv ***
// constants, types and link timing for the quad serial flash reader
// assumes one cpu-side clock and one link clock that drives the flash pins
// Operation
// - execute-in-place only with memory-mapped access selected
// - request bit set arms entry with mode byte
// - mode byte driven in next cycle's mode slots
// - status set after activating bus cycle completes
// - request bit cleared arms exit with mode byte
// - status cleared after terminating bus cycle ends
// - command phase omitted while flash is in-place
// - read-ahead only for cycles launched while prefetch enable is set
// - prefetch keeps cycle open and keeps buffering
// - address match serves buffered data, no new cycle
// - mismatch discards buffer, ends cycle, restarts read
package qsx_pkg;

  localparam int          ADDR_W     = 24;
  localparam int          BYTE_W     = 8;
  localparam int          NIB_W      = 4;

  // quad i/o fast read opcode, sent on one line
  localparam logic [7:0]  READ_CMD   = 8'hEB;

  // serial clock periods per phase, as last index of a 4-bit count
  localparam logic [3:0]  CMD_LAST   = 4'h7;
  localparam logic [3:0]  ADDR_LAST  = 4'h5;
  localparam logic [3:0]  MODE_LAST  = 4'h1;
  localparam logic [3:0]  DUMMY_LAST = 4'h3;

  // four link clocks per serial clock period
  localparam logic [1:0]  PH_LAST    = 2'h3;
  localparam logic [1:0]  PH_FIRST   = 2'h0;

  localparam logic [1:0]  FIFO_FULL  = 2'h2;

  localparam logic [3:0]  OE_NONE    = 4'h0;
  localparam logic [3:0]  OE_SINGLE  = 4'h1;
  localparam logic [3:0]  OE_QUAD    = 4'hF;

  typedef enum logic [2:0] {
    L_IDLE,
    L_CMD,
    L_ADDR,
    L_MODE,
    L_DUMMY,
    L_DATA,
    L_END
  } qsx_link_e;

  // read request handed from the cpu side to the link side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] mode;
    logic              skip_cmd;
    logic              prefetch;
    logic [1:0]        epoch;
  } qsx_cmd_s;

  // byte handed from the link side back, tagged with its request
  typedef struct packed {
    logic [1:0]        epoch;
    logic [BYTE_W-1:0] data;
  } qsx_word_s;

endpackage : qsx_pkg

// *** hdl/qsx_reader.sv ***
// memory-mapped quad serial flash reader with read-ahead and in-place mode
// assumes control inputs and cpu bus are synchronous to clk_in; the flash
// pins are timed by link_clk_in, which must run continuously
`timescale 1ns/100ps

module qsx_reader (
  input  wire logic        clk_in,                          // cpu clock
  input  wire logic        rst_in,                          // async reset
  input  wire logic        link_clk_in,                     // link clock
  input  wire logic        memory_mapped_access_select_in,  // mapped mode
  input  wire logic        prefetch_enable_in,              // read-ahead
  input  wire logic        execute_in_place_request_in,     // in-place req
  input  wire logic [7:0]  mode_data_in,                    // mode byte
  input  wire logic        cpu_req_in,                      // read request
  input  wire logic [23:0] cpu_addr_in,                     // byte address
  output logic             cpu_ready_out,                   // data pulse
  output logic [7:0]       cpu_rdata_out,                   // read data
  output logic             execute_in_place_status_out,     // in-place on
  output logic             flash_select_n_out,              // chip select
  output logic             flash_clk_out,                   // serial clock
  output logic [3:0]       flash_io_out,                    // io drive
  output logic [3:0]       flash_io_oe_out,                 // io enable
  input  wire logic [3:0]  flash_io_in                      // io sense
);

  // cpu domain state
  qsx_pkg::qsx_cmd_s  cmd;
  logic               cmd_tgl;
  logic [23:0]        head_addr;
  logic               stream_live;
  logic               stream_pf;
  logic [1:0]         epoch;
  logic [7:0]         fifo_mem [2];
  logic               wr_ptr;
  logic               rd_ptr;
  logic [1:0]         fifo_cnt;
  logic               ready;
  logic [7:0]         rdata;
  logic               req_q;
  logic [7:0]         mode_q;
  logic               change_pend;
  logic               flash_xip;
  logic               apply_wait;
  logic               apply_tgt;
  logic [1:0]         apply_id;
  logic [1:0]         launch_cnt;
  logic [1:0]         done_cnt;
  logic               xip_status;
  logic               dat_ack;
  logic               done_last;
  logic               seen_meta;
  logic               seen_sync;
  logic               dat_meta;
  logic               dat_sync;
  logic               done_meta;
  logic               done_sync;

  // link domain state
  logic               lrst_meta;
  logic               lrst;
  logic               cmd_meta;
  logic               cmd_sync;
  logic               ack_meta;
  logic               ack_sync;
  logic [3:0]         io_meta;
  logic [3:0]         io_sync;
  qsx_pkg::qsx_cmd_s  lcmd;
  logic               cmd_seen;
  qsx_pkg::qsx_link_e lst;
  logic [1:0]         ph;
  logic [3:0]         per;
  logic [7:0]         sh_cmd;
  logic [31:0]        sh;
  logic [7:0]         rx;
  logic               nib;
  logic               byte_full;
  qsx_pkg::qsx_word_s dat;
  logic               dat_tgl;
  logic               done_tgl;
  logic               cs_n;
  logic               sclk;
  logic [3:0]         io_out;
  logic [3:0]         io_oe;

  function automatic logic [1:0] inc2(input logic [1:0] v);
    inc2 = v + 2'h1;
  endfunction : inc2

  // cpu side decisions
  logic req_eff;
  logic chg;
  logic chan_free;
  logic take;
  logic match;
  logic serve;
  logic launch;
  logic dat_new;
  logic stale;
  logic push;
  logic done_evt;

  assign req_eff   = execute_in_place_request_in &
                     memory_mapped_access_select_in;
  assign chg       = (req_eff != req_q) | (mode_data_in != mode_q);
  assign chan_free = (seen_sync == cmd_tgl);
  assign take      = cpu_req_in & ~ready &
                     memory_mapped_access_select_in;
  assign match     = (cpu_addr_in == head_addr);
  assign serve     = take & match & (fifo_cnt != 2'h0);
  // a matching read with the stream still open waits for its byte
  assign launch    = take & chan_free & ~(match &
                     ((fifo_cnt != 2'h0) | stream_live));
  assign dat_new   = (dat_sync != dat_ack);
  assign stale     = (dat.epoch != epoch);
  assign push      = dat_new & ~stale & ~launch &
                     (fifo_cnt != qsx_pkg::FIFO_FULL);
  assign done_evt  = (done_sync != done_last);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_meta <= 1'b0;
      seen_sync <= 1'b0;
      dat_meta  <= 1'b0;
      dat_sync  <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_last <= 1'b0;
    end else begin
      seen_meta <= cmd_seen;
      seen_sync <= seen_meta;
      dat_meta  <= dat_tgl;
      dat_sync  <= dat_meta;
      done_meta <= done_tgl;
      done_sync <= done_meta;
      done_last <= done_sync;
    end
  end

  // request launch; a new address throws away what was read ahead
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd         <= '0;
      cmd_tgl     <= 1'b0;
      head_addr   <= '0;
      stream_live <= 1'b0;
      stream_pf   <= 1'b0;
      epoch       <= 2'h0;
    end else if (launch) begin
      cmd.addr     <= cpu_addr_in;
      cmd.mode     <= mode_data_in;
      cmd.skip_cmd <= flash_xip;
      cmd.prefetch <= prefetch_enable_in;
      cmd.epoch    <= inc2(epoch);
      cmd_tgl      <= ~cmd_tgl;
      head_addr    <= cpu_addr_in;
      stream_live  <= 1'b1;
      stream_pf    <= prefetch_enable_in;
      epoch        <= inc2(epoch);
    end else if (serve) begin
      head_addr <= head_addr + 24'h1;
      // without read-ahead the cycle carries a single byte
      if (!stream_pf) begin
        stream_live <= 1'b0;
      end
    end
  end

  // two-entry buffer; when full the link side is not acknowledged and
  // stops its serial clock, so no byte is lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      fifo_cnt <= 2'h0;
      dat_ack  <= 1'b0;
    end else begin
      if (dat_new & (stale | launch | (fifo_cnt != qsx_pkg::FIFO_FULL))) begin
        dat_ack <= dat_sync;
      end
      if (launch) begin
        wr_ptr   <= 1'b0;
        rd_ptr   <= 1'b0;
        fifo_cnt <= 2'h0;
      end else begin
        if (push) begin
          wr_ptr <= ~wr_ptr;
        end
        if (serve) begin
          rd_ptr <= ~rd_ptr;
        end
        fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, serve};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      fifo_mem[wr_ptr] <= dat.data;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ready <= serve;
      if (serve) begin
        rdata <= fifo_mem[rd_ptr];
      end
    end
  end

  // in-place tracking: the flash follows the mode byte at once, the
  // status only once the carrying cycle has ended
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_q       <= 1'b0;
      mode_q      <= 8'h00;
      change_pend <= 1'b0;
      flash_xip   <= 1'b0;
      apply_wait  <= 1'b0;
      apply_tgt   <= 1'b0;
      apply_id    <= 2'h0;
      launch_cnt  <= 2'h0;
      done_cnt    <= 2'h0;
      xip_status  <= 1'b0;
    end else begin
      req_q       <= req_eff;
      mode_q      <= mode_data_in;
      change_pend <= chg | (change_pend & ~launch);
      if (done_evt) begin
        done_cnt <= inc2(done_cnt);
        if (apply_wait && (done_cnt == apply_id)) begin
          xip_status <= apply_tgt;
          apply_wait <= 1'b0;
        end
      end
      if (launch) begin
        launch_cnt <= inc2(launch_cnt);
        if (change_pend | chg) begin
          flash_xip  <= req_eff;
          apply_wait <= 1'b1;
          apply_tgt  <= req_eff;
          apply_id   <= launch_cnt;
        end
      end
    end
  end

  assign cpu_ready_out               = ready;
  assign cpu_rdata_out               = rdata;
  assign execute_in_place_status_out = xip_status;

  // link domain: reset release and input synchronisers
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lrst_meta <= 1'b1;
      lrst      <= 1'b1;
    end else begin
      lrst_meta <= 1'b0;
      lrst      <= lrst_meta;
    end
  end

  always_ff @(posedge link_clk_in or posedge lrst) begin
    if (lrst) begin
      cmd_meta <= 1'b0;
      cmd_sync <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      io_meta  <= 4'h0;
      io_sync  <= 4'h0;
    end else begin
      cmd_meta <= cmd_tgl;
      cmd_sync <= cmd_meta;
      ack_meta <= dat_ack;
      ack_sync <= ack_meta;
      io_meta  <= flash_io_in;
      io_sync  <= io_meta;
    end
  end

  logic       cmd_new;
  logic       dat_free;
  logic       stall;
  logic [1:0] ph_nx;

  assign cmd_new  = (cmd_sync != cmd_seen);
  assign dat_free = (ack_sync == dat_tgl);
  assign ph_nx    = ph + 2'h1;
  // hold the serial clock low until the buffer takes the last byte
  assign stall    = (lst == qsx_pkg::L_DATA) & (ph == qsx_pkg::PH_FIRST) &
                    byte_full & ~dat_free;

  // serial engine: outputs change on the falling edge (phase 0), input
  // nibbles are taken in phase 3, which sees the pins two clocks back
  always_ff @(posedge link_clk_in or posedge lrst) begin
    if (lrst) begin
      lst       <= qsx_pkg::L_IDLE;
      lcmd      <= '0;
      cmd_seen  <= 1'b0;
      ph        <= 2'h0;
      per       <= 4'h0;
      sh_cmd    <= 8'h00;
      sh        <= 32'h0;
      rx        <= 8'h00;
      nib       <= 1'b0;
      byte_full <= 1'b0;
      dat       <= '0;
      dat_tgl   <= 1'b0;
      done_tgl  <= 1'b0;
      cs_n      <= 1'b1;
      sclk      <= 1'b0;
      io_out    <= 4'h0;
      io_oe     <= qsx_pkg::OE_NONE;
    end else begin
      case (lst)
        qsx_pkg::L_IDLE: begin
          cs_n  <= 1'b1;
          sclk  <= 1'b0;
          io_oe <= qsx_pkg::OE_NONE;
          if (cmd_new) begin
            cmd_seen  <= cmd_sync;
            lcmd      <= cmd;
            cs_n      <= 1'b0;
            ph        <= 2'h0;
            per       <= 4'h0;
            byte_full <= 1'b0;
            nib       <= 1'b0;
            if (cmd.skip_cmd) begin
              lst    <= qsx_pkg::L_ADDR;
              io_out <= cmd.addr[23:20];
              io_oe  <= qsx_pkg::OE_QUAD;
              sh     <= {cmd.addr[19:0], cmd.mode, 4'h0};
            end else begin
              lst    <= qsx_pkg::L_CMD;
              io_out <= {3'h0, qsx_pkg::READ_CMD[7]};
              io_oe  <= qsx_pkg::OE_SINGLE;
              sh_cmd <= {qsx_pkg::READ_CMD[6:0], 1'b0};
              sh     <= {cmd.addr, cmd.mode};
            end
          end
        end
        qsx_pkg::L_END: begin
          cs_n  <= 1'b1;
          sclk  <= 1'b0;
          io_oe <= qsx_pkg::OE_NONE;
          ph    <= ph_nx;
          if (ph == qsx_pkg::PH_LAST) begin
            done_tgl <= ~done_tgl;
            lst      <= qsx_pkg::L_IDLE;
          end
        end
        default: begin
          // a high serial clock is let finish, so the flash never sees a
          // clock pulse shorter than two link clocks
          if (cmd_new && (!sclk || (ph == qsx_pkg::PH_LAST))) begin
            lst   <= qsx_pkg::L_END;
            ph    <= 2'h0;
            cs_n  <= 1'b1;
            sclk  <= 1'b0;
            io_oe <= qsx_pkg::OE_NONE;
          end else if (!stall) begin
            ph   <= ph_nx;
            sclk <= ph_nx[1];
            if (ph == qsx_pkg::PH_LAST) begin
              per <= per + 4'h1;
            end
            case (lst)
              qsx_pkg::L_CMD: begin
                if (ph == qsx_pkg::PH_LAST) begin
                  if (per == qsx_pkg::CMD_LAST) begin
                    lst    <= qsx_pkg::L_ADDR;
                    per    <= 4'h0;
                    io_out <= sh[31:28];
                    io_oe  <= qsx_pkg::OE_QUAD;
                    sh     <= {sh[27:0], 4'h0};
                  end else begin
                    io_out <= {3'h0, sh_cmd[7]};
                    sh_cmd <= {sh_cmd[6:0], 1'b0};
                  end
                end
              end
              qsx_pkg::L_ADDR: begin
                if (ph == qsx_pkg::PH_LAST) begin
                  if (per == qsx_pkg::ADDR_LAST) begin
                    lst <= qsx_pkg::L_MODE;
                    per <= 4'h0;
                  end
                  io_out <= sh[31:28];
                  sh     <= {sh[27:0], 4'h0};
                end
              end
              qsx_pkg::L_MODE: begin
                if (ph == qsx_pkg::PH_LAST) begin
                  if (per == qsx_pkg::MODE_LAST) begin
                    lst   <= qsx_pkg::L_DUMMY;
                    per   <= 4'h0;
                    io_oe <= qsx_pkg::OE_NONE;
                  end else begin
                    io_out <= sh[31:28];
                    sh     <= {sh[27:0], 4'h0};
                  end
                end
              end
              qsx_pkg::L_DUMMY: begin
                if ((ph == qsx_pkg::PH_LAST) &&
                    (per == qsx_pkg::DUMMY_LAST)) begin
                  lst <= qsx_pkg::L_DATA;
                  per <= 4'h0;
                end
              end
              default: begin
                if (ph == qsx_pkg::PH_LAST) begin
                  rx  <= {rx[3:0], io_sync};
                  nib <= ~nib;
                  if (nib) begin
                    byte_full <= 1'b1;
                  end
                end
                if ((ph == qsx_pkg::PH_FIRST) && byte_full) begin
                  dat.epoch <= lcmd.epoch;
                  dat.data  <= rx;
                  dat_tgl   <= ~dat_tgl;
                  byte_full <= 1'b0;
                  if (!lcmd.prefetch) begin
                    lst  <= qsx_pkg::L_END;
                    ph   <= 2'h0;
                    cs_n <= 1'b1;
                    sclk <= 1'b0;
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign flash_select_n_out = cs_n;
  assign flash_clk_out      = sclk;
  assign flash_io_out       = io_out;
  assign flash_io_oe_out    = io_oe;

endmodule : qsx_reader
